// ---- hdl/gpb_pkg.sv ----
/*
 * Package for the three general-purpose pin bank controllers.
 * Holds the memory map, register offsets, bank widths, pin layout and reset values.
 * Assumes a single processor-side register port with word-aligned 32-bit accesses.
 */
package gpb_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [31:0] GPB_PERIPH_BASE = 32'hfc000000;
    localparam logic [31:0] GPB_PERIPH_SIZE = 32'h00010000;
    localparam logic [31:0] GPB_BANK0_BASE = 32'hff708000;
    localparam logic [31:0] GPB_BANK1_BASE = 32'hff709000;
    localparam logic [31:0] GPB_BANK2_BASE = 32'hff70a000;
    localparam int GPB_WIN_BITS = 12;
    localparam int GPB_NBANK = 3;

    // ------------------------------------------------------------------
    // Register offsets inside one bank window
    // ------------------------------------------------------------------
    localparam logic [11:0] GPB_OFS_OUT_VALUE = 12'h000;
    localparam logic [11:0] GPB_OFS_DIRECTION = 12'h004;
    localparam logic [11:0] GPB_OFS_IN_LEVEL = 12'h050;

    // ------------------------------------------------------------------
    // Pin layout
    // ------------------------------------------------------------------
    localparam int GPB_REG_W = 32;
    localparam int GPB_BANK0_PINS = 29;
    localparam int GPB_BANK1_PINS = 29;
    localparam int GPB_BANK2_IO_PINS = 13;
    localparam int GPB_BANK2_IN_PINS = 14;
    localparam int GPB_BANK2_PINS = GPB_BANK2_IO_PINS + GPB_BANK2_IN_PINS;
    localparam int GPB_IO_PINS = 71;
    localparam int GPB_LED_BIT = 24;
    localparam int GPB_KEY_BIT = 25;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] GPB_RST_DIRECTION = 32'h00000000;
    localparam logic [31:0] GPB_RST_OUT_VALUE = 32'h00000000;
    localparam logic [31:0] GPB_RD_UNMAPPED = 32'h00000000;

    // Register-port request carried as one bundle
    typedef struct packed {
        logic sel;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } gpb_req_s;

endpackage

// ---- hdl/gpb_bank.sv ----
/*
 * One pin bank controller: direction, output value and input level registers.
 * Assumes the parent has decoded the bank window and synchronised the pin levels.
 */
`timescale 1ns/100ps

module gpb_bank #(
    parameter int NPINS = 29,   // Pins served, LSB upward
    parameter int NDRV = 29     // Low pins that may be driven
) (
    input wire logic clk_sys,               // System clock
    input wire logic rst_n,                 // Synchronised reset, active low
    input wire logic ce,                    // Clock enable
    input wire logic wr_en,                 // Write strobe for this bank
    input wire logic [11:0] ofs,            // Offset in window
    input wire logic [31:0] wdata,          // Write data
    input wire logic [NPINS-1:0] pin_level, // Synchronised pin levels
    output logic [31:0] rdata,              // Read data, combinational
    output logic rhit,                      // Offset is mapped
    output logic [NPINS-1:0] pin_out,       // Output level
    output logic [NPINS-1:0] pin_oe         // Drive enable
);
    import gpb_pkg::*;

    // Elaboration guard: the read mux and the pin loop cannot serve these counts
    if (NPINS < 1 || NPINS > GPB_REG_W || NDRV < 0 || NDRV > NPINS) begin : g_bad_counts
        $error("gpb_bank: pin counts out of range");
    end

    logic [NPINS-1:0] dir_ff;
    logic [NPINS-1:0] outv_ff;

    // -----------------------------------------------------------------
    // Writable registers
    // -----------------------------------------------------------------
    // Both start cleared so every pin is an input until software says so
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_ff <= GPB_RST_DIRECTION[NPINS-1:0];
        end else if (ce && wr_en && ofs == GPB_OFS_DIRECTION) begin
            dir_ff <= wdata[NPINS-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outv_ff <= GPB_RST_OUT_VALUE[NPINS-1:0];
        end else if (ce && wr_en && ofs == GPB_OFS_OUT_VALUE) begin
            outv_ff <= wdata[NPINS-1:0];
        end
    end

    // Per-pin drive; input-only pins above NDRV never get an enable
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            if (gi < NDRV) begin : g_drv
                assign pin_oe[gi] = dir_ff[gi];
                assign pin_out[gi] = outv_ff[gi];
            end else begin : g_in
                assign pin_oe[gi] = 1'b0;
                assign pin_out[gi] = 1'b0;
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Read mux; input level register has no write path
    // -----------------------------------------------------------------
    always_comb begin
        rdata = GPB_RD_UNMAPPED;
        rhit = 1'b1;
        case (ofs)
            GPB_OFS_OUT_VALUE: rdata[NPINS-1:0] = outv_ff;
            GPB_OFS_DIRECTION: rdata[NPINS-1:0] = dir_ff;
            GPB_OFS_IN_LEVEL: rdata[NPINS-1:0] = pin_level;
            default: rhit = 1'b0;
        endcase
    end

endmodule

// ---- hdl/gpb_top.sv ----
/*
 * Three general-purpose pin bank controllers behind one processor register port.
 * Assumes the port presents full 32-bit word accesses, one per sel cycle, and that
 * external logic resolves the pin wires from pin_o and pin_oe.
 */
`timescale 1ns/100ps

module gpb_top (
    input wire logic clk_sys,                          // 10 MHz system clock
    input wire logic reset_n,                          // Async reset, active low
    input wire logic ce,                               // Clock enable, freezes state
    input wire gpb_pkg::gpb_req_s req,                 // Register request
    output logic [31:0] rdata,                         // Read data, valid with rvalid
    output logic rvalid,                               // Answer pulse
    output logic rerr,                                 // Unmapped address on answer
    input wire logic [gpb_pkg::GPB_IO_PINS-1:0] pin_in, // Two-way pin levels
    input wire logic [gpb_pkg::GPB_BANK2_IN_PINS-1:0] in_only_pin, // Input-only pins
    output logic [gpb_pkg::GPB_IO_PINS-1:0] pin_o,     // Two-way pin output level
    output logic [gpb_pkg::GPB_IO_PINS-1:0] pin_oe,    // Two-way pin drive enable
    output logic user_led_pin,                          // Level for the user LED
    output logic user_button_pin                        // Synchronised button level
);
    import gpb_pkg::*;

    // All synchronised levels: two-way pins low, input-only pins above them
    localparam int NALL = GPB_IO_PINS + GPB_BANK2_IN_PINS;

    // -----------------------------------------------------------------
    // Layout guard
    // -----------------------------------------------------------------
    // The bank slices below assume the three banks tile the two-way pins exactly
    if (GPB_BANK0_PINS + GPB_BANK1_PINS + GPB_BANK2_IO_PINS != GPB_IO_PINS) begin : g_bad_layout
        $error("gpb_top: bank pin counts do not add up");
    end
    if (GPB_LED_BIT >= GPB_BANK1_PINS || GPB_KEY_BIT >= GPB_BANK1_PINS) begin : g_bad_board
        $error("gpb_top: board pin bits outside the second bank");
    end

    // -----------------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    // Assert at once, release two edges late so no flop leaves reset on a marginal edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // -----------------------------------------------------------------
    // Pin synchronisers; first stage feeds only the second
    // -----------------------------------------------------------------
    logic [NALL-1:0] meta_ff;
    logic [NALL-1:0] lvl_ff;

    // Freezing with ce may age a sample; that is accepted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            lvl_ff <= '0;
        end else if (ce) begin
            meta_ff <= {in_only_pin, pin_in};
            lvl_ff <= meta_ff;
        end
    end

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    logic [GPB_NBANK-1:0] bank_hit;
    logic [11:0] ofs;
    logic in_region;

    // Every bank sees the same offset; only the bank whose window hits acts on it
    assign ofs = req.addr[GPB_WIN_BITS-1:0];
    // Banks sit outside the generic region, so region only gates legality
    assign in_region = (req.addr - GPB_PERIPH_BASE) < GPB_PERIPH_SIZE;
    // Window match on the upper address bits; each window spans 4KB
    always_comb begin
        bank_hit[0] = req.addr[31:GPB_WIN_BITS] == GPB_BANK0_BASE[31:GPB_WIN_BITS];
        bank_hit[1] = req.addr[31:GPB_WIN_BITS] == GPB_BANK1_BASE[31:GPB_WIN_BITS];
        bank_hit[2] = req.addr[31:GPB_WIN_BITS] == GPB_BANK2_BASE[31:GPB_WIN_BITS];
    end

    // -----------------------------------------------------------------
    // Banks
    // -----------------------------------------------------------------
    logic [31:0] rd0;
    logic [31:0] rd1;
    logic [31:0] rd2;
    logic [2:0] hit;
    logic [GPB_BANK0_PINS-1:0] o0;
    logic [GPB_BANK0_PINS-1:0] e0;
    logic [GPB_BANK1_PINS-1:0] o1;
    logic [GPB_BANK1_PINS-1:0] e1;
    logic [GPB_BANK2_PINS-1:0] o2;
    logic [GPB_BANK2_PINS-1:0] e2;
    logic wr_any;

    // Write strobe before the bank select, shared by all three banks
    assign wr_any = req.sel && req.wr;

    // Pins 0..28
    gpb_bank #(.NPINS(GPB_BANK0_PINS), .NDRV(GPB_BANK0_PINS)) u_first_pin_controller (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_any && bank_hit[0]),
        .ofs(ofs),
        .wdata(req.wdata),
        .pin_level(lvl_ff[GPB_BANK0_PINS-1:0]),
        .rdata(rd0),
        .rhit(hit[0]),
        .pin_out(o0),
        .pin_oe(e0)
    );

    // Pins 29..57, pin 29 on bit 0
    gpb_bank #(.NPINS(GPB_BANK1_PINS), .NDRV(GPB_BANK1_PINS)) u_second_pin_controller (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_any && bank_hit[1]),
        .ofs(ofs),
        .wdata(req.wdata),
        .pin_level(lvl_ff[GPB_BANK0_PINS +: GPB_BANK1_PINS]),
        .rdata(rd1),
        .rhit(hit[1]),
        .pin_out(o1),
        .pin_oe(e1)
    );

    // Pins 58..70 on low bits, input-only pins above them
    gpb_bank #(.NPINS(GPB_BANK2_PINS), .NDRV(GPB_BANK2_IO_PINS)) u_third_pin_controller (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(wr_any && bank_hit[2]),
        .ofs(ofs),
        .wdata(req.wdata),
        .pin_level(lvl_ff[NALL-1:GPB_BANK0_PINS+GPB_BANK1_PINS]),
        .rdata(rd2),
        .rhit(hit[2]),
        .pin_out(o2),
        .pin_oe(e2)
    );

    // -----------------------------------------------------------------
    // Registered answer, one cycle after the request
    // -----------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic nxt_rerr;

    // Writes answer with zero data so a stale read value never leaks out
    always_comb begin
        nxt_rdata = GPB_RD_UNMAPPED;
        nxt_rerr = 1'b1;
        if (bank_hit[0] && hit[0]) begin
            nxt_rdata = rd0;
            nxt_rerr = 1'b0;
        end else if (bank_hit[1] && hit[1]) begin
            nxt_rdata = rd1;
            nxt_rerr = 1'b0;
        end else if (bank_hit[2] && hit[2]) begin
            nxt_rdata = rd2;
            nxt_rerr = 1'b0;
        end else if (in_region) begin
            nxt_rerr = 1'b0; // Region is claimed but holds nothing here
        end
        if (req.wr) begin
            nxt_rdata = GPB_RD_UNMAPPED;
        end
    end

    // Answer is stored only while ce is high, so a frozen cycle holds it unchanged
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
            rvalid <= 1'b0;
            rerr <= 1'b0;
        end else if (ce) begin
            rvalid <= req.sel;
            rerr <= req.sel && nxt_rerr;
            rdata <= req.sel ? nxt_rdata : 32'h00000000;
        end
    end

    // -----------------------------------------------------------------
    // Pin outputs, registered so drive changes come from flip-flops
    // -----------------------------------------------------------------
    // Costs one cycle of latency between a register write and the pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_o <= '0;
            pin_oe <= '0;
            user_led_pin <= 1'b0;
            user_button_pin <= 1'b0;
        end else if (ce) begin
            pin_o <= {o2[GPB_BANK2_IO_PINS-1:0], o1, o0};
            pin_oe <= {e2[GPB_BANK2_IO_PINS-1:0], e1, e0};
            // LED lights only while its pin is also set to drive
            user_led_pin <= o1[GPB_LED_BIT] & e1[GPB_LED_BIT];
            user_button_pin <= lvl_ff[GPB_BANK0_PINS + GPB_KEY_BIT];
        end
    end

endmodule

// ---- verification/gpb_checker.sv ----
/* Port-level checks for the pin bank top.
   Assumes it is bound to gpb_top and sees its ports only. */
`timescale 1ns/100ps
module gpb_checker (
    input wire logic clk_sys, // System clock
    input wire logic reset_n, // Reset, active low
    input wire logic ce, // Clock enable
    input wire gpb_pkg::gpb_req_s req, // Register request
    input wire logic rvalid, // Answer pulse
    input wire logic rerr, // Unmapped flag
    input wire logic [70:0] pin_in, // Pin levels
    input wire logic [70:0] pin_o, // Output levels
    input wire logic [70:0] pin_oe, // Drive enables
    input wire logic user_led_pin, // LED level
    input wire logic user_button_pin // Button level
);
    import gpb_pkg::*;
    // ----------------
    // Expected decode
    // ----------------
    logic in_bank;
    logic ofs_ok;
    logic exp_err;
    logic wr_go;
    // Only the window number is compared, so any 4KB slip shows up
    assign in_bank = req.addr[31:12] inside {GPB_BANK0_BASE[31:12], GPB_BANK1_BASE[31:12],
        GPB_BANK2_BASE[31:12]};
    assign ofs_ok = req.addr[11:0] inside {GPB_OFS_OUT_VALUE, GPB_OFS_DIRECTION, GPB_OFS_IN_LEVEL};
    assign exp_err = !((in_bank && ofs_ok) || req.addr[31:16] == GPB_PERIPH_BASE[31:16]);
    assign wr_go = ce && req.sel && req.wr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----------------
    // Assertions
    // ----------------
    chk_answer_pulse: assert property (ce && req.sel |=> rvalid)
        else $error("request got no answer");
    chk_no_stray: assert property (ce && !req.sel |=> !rvalid)
        else $error("answer without request");
    chk_err_decode: assert property (ce && req.sel |=> rerr == $past(exp_err))
        else $error("unmapped flag wrong");
    chk_dir_to_oe: assert property (wr_go && req.addr == GPB_BANK1_BASE + GPB_OFS_DIRECTION
        ##1 ce |=> pin_oe[57:29] == $past(req.wdata[28:0], 2))
        else $error("drive enables do not follow direction");
    chk_val_to_out: assert property (wr_go && req.addr == GPB_BANK1_BASE + GPB_OFS_OUT_VALUE
        ##1 ce |=> pin_o[57:29] == $past(req.wdata[28:0], 2))
        else $error("output levels do not follow value");
    chk_led_gated: assert property (user_led_pin |-> pin_oe[53] && pin_o[53])
        else $error("LED lit while not driven high");
    chk_reset_idle: assert property ($rose(reset_n) |-> (pin_oe == '0 && pin_o == '0)[*2])
        else $error("pins driven out of reset");
    chk_button_sync: assert property ((ce && $stable(pin_in[54]))[*8]
        |-> user_button_pin == pin_in[54])
        else $error("button level not tracking pin");
    // Main scenarios reached
    cover property (wr_go);
    cover property (rvalid && rerr);
    cover property (user_led_pin && user_button_pin);
endmodule

bind gpb_top gpb_checker i_gpb_checker (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .req(req), .rvalid(rvalid), .rerr(rerr), .pin_in(pin_in), .pin_o(pin_o),
    .pin_oe(pin_oe), .user_led_pin(user_led_pin), .user_button_pin(user_button_pin));

// ---- verification/gpb_pins.sv ----
/* Board side of the two-way pins: buttons and LEDs.
   Assumes the bench supplies the level each undriven pin is pulled to. */
`timescale 1ns/100ps
module gpb_pins (
    input wire logic [70:0] pin_o, // Device output level
    input wire logic [70:0] pin_oe, // Device drive enable
    input wire logic [70:0] ext_lvl, // Board level of undriven pins
    output logic [70:0] pin_in // Resolved wire level
);
    // Device wins where it drives, so an output pin reads back its own level
    assign pin_in = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

// ---- verification/tb.sv ----
/* Self-checking bench for the pin bank top.
   Assumes the board model and checker files are compiled before it. */
`timescale 1ns/100ps
module tb;
    import gpb_pkg::*;
    // ----------------
    // Signals
    // ----------------
    typedef struct packed {
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rd;
        logic err;
    } gpb_row_s;
    localparam logic [31:0] A0 = GPB_BANK0_BASE;
    localparam logic [31:0] A1 = GPB_BANK1_BASE;
    localparam logic [31:0] A2 = GPB_BANK2_BASE;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    gpb_req_s req = '0;
    logic [31:0] rdata;
    logic rvalid, rerr, user_led_pin, user_button_pin;
    logic [70:0] pin_in, pin_o, pin_oe;
    logic [70:0] ext_lvl = '0;
    logic [13:0] in_only_pin = 14'h2a5a;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    // Ordinary accesses: direction is set before the value that it gates
    gpb_row_s rows [15] = '{
        '{1'b0, A0 + GPB_OFS_DIRECTION, 32'h0, 32'h0, 1'b0}, '{1'b0, A1 + GPB_OFS_OUT_VALUE,
        32'h0, 32'h0, 1'b0}, '{1'b1, A1 + GPB_OFS_DIRECTION, 32'h01000000, 32'h0, 1'b0},
        '{1'b1, A1 + GPB_OFS_OUT_VALUE, 32'h01000000, 32'h0, 1'b0},
        '{1'b0, A1 + GPB_OFS_DIRECTION, 32'h0, 32'h01000000, 1'b0},
        '{1'b0, A1 + GPB_OFS_OUT_VALUE, 32'h0, 32'h01000000, 1'b0},
        '{1'b1, A2 + GPB_OFS_IN_LEVEL, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, A0 + 32'h8, 32'h0, 32'h0, 1'b1}, '{1'b0, GPB_PERIPH_BASE + 32'h10, 32'h0, 32'h0,
        1'b0}, '{1'b0, GPB_PERIPH_BASE + GPB_PERIPH_SIZE, 32'h0, 32'h0, 1'b1},
        '{1'b0, A2 + 32'h1000, 32'h0, 32'h0, 1'b1},
        '{1'b1, A0 + GPB_OFS_DIRECTION, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, A0 + GPB_OFS_DIRECTION, 32'h0, 32'h1fffffff, 1'b0},
        '{1'b1, A2 + GPB_OFS_DIRECTION, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, A2 + GPB_OFS_DIRECTION, 32'h0, 32'h07ffffff, 1'b0}};
    gpb_top i_gpb_top (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .req(req),
        .rdata(rdata), .rvalid(rvalid), .rerr(rerr), .pin_in(pin_in), .in_only_pin(in_only_pin),
        .pin_o(pin_o), .pin_oe(pin_oe), .user_led_pin(user_led_pin),
        .user_button_pin(user_button_pin));
    gpb_pins i_gpb_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
    // ----------------
    // Tasks
    // ----------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access; sel drops at the answer edge, so calls never collide
    task automatic access(input gpb_row_s r);
        @(posedge clk_sys);
        req <= '{1'b1, r.wr, r.addr, r.wdata};
        @(posedge clk_sys);
        req.sel <= 1'b0;
        #1;
        check("rvalid", 32'h1, {31'h0, rvalid});
        check("rerr", {31'h0, r.err}, {31'h0, rerr});
        check("rdata", r.rd, rdata);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Clock and hang guard; the run needs well under 300 cycles
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (rows[i]) access(rows[i]);
        // Press the button and let the synchronisers settle
        @(posedge clk_sys);
        ext_lvl[54] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check("led", 32'h1, {31'h0, user_led_pin});
        check("button", 32'h1, {31'h0, user_button_pin});
        check("oe_b0", 32'h1fffffff, {3'h0, pin_oe[28:0]});
        check("oe_b1", 32'h01000000, {3'h0, pin_oe[57:29]});
        check("oe_b2", 32'h00001fff, {19'h0, pin_oe[70:58]});
        check("out_b1", 32'h01000000, {3'h0, pin_o[57:29]});
        access('{1'b0, A1 + GPB_OFS_IN_LEVEL, 32'h0, 32'h03000000, 1'b0});
        access('{1'b0, A2 + GPB_OFS_IN_LEVEL, 32'h0, {5'h0, in_only_pin, 13'h0}, 1'b0});
        // Frozen clock enable swallows a request
        @(posedge clk_sys);
        ce <= 1'b0;
        req <= '{1'b1, 1'b0, A1 + GPB_OFS_DIRECTION, 32'h0};
        @(posedge clk_sys);
        req.sel <= 1'b0;
        ce <= 1'b1;
        #1;
        check("frozen", 32'h0, {31'h0, rvalid});
        // Second reset in mid-run clears the registers
        @(posedge clk_sys);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("oe_reset", 32'h0, {3'h0, pin_oe[57:29]});
        access('{1'b0, A1 + GPB_OFS_DIRECTION, 32'h0, 32'h0, 1'b0});
        report_and_stop();
    end
endmodule
